// *** src/tmr_timer.v ***
`timescale 1ns/1ps
// How it works
// - clock input divided by 1, 2, 4 or 8 per prescale_select
// - prescale counter hidden; cleared on any count byte write outside wide mode
// - in wide mode a high byte write leaves the prescale counter alone
// - nosync bit counts from the external input after two flops, without the agreement check
// - asynchronous external mode keeps counting while asleep; overflow wakes
// - switching sync mode may drop or add one increment
// - byte reads while counting asynchronously always return a settled value
// - wide_access_enable routes all high byte access through a holding buffer
// - low byte read copies live high byte into the buffer
// - low byte write loads buffered high byte, all 16 bits change together
// - flags set by hardware regardless of mask
// - flags stay set until software writes one to clear
`include "tmr_consts.vh"
module tmr_timer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_clk,
	input wire gate_in,
	input wire sleep,
	output reg irq,
	output reg wake
);
	reg [6:0] ctrl_q;
	reg [15:0] cnt_q;
	reg [7:0] hibuf_q;
	reg [2:0] ps_q;
	reg [1:0] flag_q;
	reg [1:0] mask_q;
	reg [2:0] ext_sync_q;
	reg [2:0] gate_sync_q;
	reg ext_prev_q;
	reg gate_prev_q;
	wire acc;
	wire wr;
	wire rd;
	wire run;
	wire wide;
	wire nosync;
	wire extsel;
	wire [1:0] psel_f;
	wire ext_now;
	wire ext_rise;
	wire gate_now;
	wire gate_edge;
	wire tick;
	wire ps_hit;
	wire inc;
	wire wr_lo;
	wire wr_hi;
	wire rd_lo;
	wire ovf;
	reg [31:0] rdata_d;
	function [2:0] ps_limit;
		input [1:0] sel;
		begin
			case (sel)
				2'b00: ps_limit = 3'h0;
				2'b01: ps_limit = 3'h1;
				2'b10: ps_limit = 3'h3;
				default: ps_limit = 3'h7;
			endcase
		end
	endfunction
	assign acc = psel & penable & ~pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign run = ctrl_q[`TMR_CTRL_RUN];
	assign wide = ctrl_q[`TMR_CTRL_WIDE];
	assign nosync = ctrl_q[`TMR_CTRL_NOSYNC];
	assign extsel = ctrl_q[`TMR_CTRL_EXTSEL];
	assign psel_f = ctrl_q[`TMR_CTRL_PS_HI:`TMR_CTRL_PS_LO];
	// async mode samples after two flops, skipping the agreement check: fewer cycles of latency, and
	// the mode change can lose or add one increment
	// sync mode only takes a level once the second and third flops agree
	assign ext_now = nosync ? ext_sync_q[1] :
		((ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] :
		ext_prev_q);
	assign ext_rise = ext_now & ~ext_prev_q;
	assign gate_now = (gate_sync_q[1] == gate_sync_q[2]) ?
		gate_sync_q[2] : gate_prev_q;
	assign gate_edge = gate_now & ~gate_prev_q;
	// sleep stops the system-clock source and the synchronised external source
	assign tick = run & (extsel ? (ext_rise & (nosync | ~sleep)) :
		~sleep);
	assign ps_hit = (ps_q == ps_limit(psel_f));
	assign inc = tick & ps_hit;
	assign wr_lo = wr & (paddr == `TMR_ADDR_CNT_LO);
	assign wr_hi = wr & (paddr == `TMR_ADDR_CNT_HI);
	assign rd_lo = rd & (paddr == `TMR_ADDR_CNT_LO);
	assign ovf = inc & (cnt_q == 16'hFFFF) & ~wr_lo & ~(wr_hi & ~wide);
	always @* begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			`TMR_ADDR_CTRL: rdata_d = {25'h000_0000, ctrl_q};
			`TMR_ADDR_CNT_LO: rdata_d = {24'h00_0000, cnt_q[7:0]};
			`TMR_ADDR_CNT_HI: rdata_d = {24'h00_0000,
				wide ? hibuf_q : cnt_q[15:8]};
			`TMR_ADDR_STATUS: rdata_d = {30'h0000_0000, flag_q};
			`TMR_ADDR_MASK: rdata_d = {30'h0000_0000, mask_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_q <= 3'h0;
			gate_sync_q <= 3'h0;
			ext_prev_q <= 1'b0;
			gate_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_clk};
			gate_sync_q <= {gate_sync_q[1:0], gate_in};
			ext_prev_q <= ext_now;
			gate_prev_q <= gate_now;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc;
			pslverr <= acc & (paddr > `TMR_ADDR_MASK);
			if (rd)
				prdata <= rdata_d;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `TMR_CTRL_RST;
			mask_q <= 2'h0;
		end else if (wr) begin
			if (paddr == `TMR_ADDR_CTRL)
				ctrl_q <= pwdata[6:0];
			if (paddr == `TMR_ADDR_MASK)
				mask_q <= pwdata[1:0];
		end
	end
	// prescale counter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q <= 3'h0;
		end else if (wr_lo | (wr_hi & ~wide)) begin
			ps_q <= 3'h0;
		end else if (tick) begin
			ps_q <= ps_hit ? 3'h0 : ps_q + 3'h1;
		end
	end
	// writes win over a colliding increment
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= `TMR_CNT_RST;
			hibuf_q <= 8'h00;
		end else begin
			if (wr_lo) begin
				cnt_q[7:0] <= pwdata[7:0];
				if (wide)
					cnt_q[15:8] <= hibuf_q;
			end else if (wr_hi & ~wide) begin
				cnt_q[15:8] <= pwdata[7:0];
			end else if (inc) begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (wr_hi & wide)
				hibuf_q <= pwdata[7:0];
			else if (rd_lo & wide)
				hibuf_q <= cnt_q[15:8];
		end
	end
	// set wins over clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 2'h0;
			irq <= 1'b0;
			wake <= 1'b0;
		end else begin
			flag_q[`TMR_ST_OVF] <= ovf | (flag_q[`TMR_ST_OVF] &
				~(wr & (paddr == `TMR_ADDR_STATUS) &
				pwdata[`TMR_ST_OVF]));
			flag_q[`TMR_ST_GATE] <= (gate_edge & run) |
				(flag_q[`TMR_ST_GATE] & ~(wr &
				(paddr == `TMR_ADDR_STATUS) & pwdata[`TMR_ST_GATE]));
			irq <= |(flag_q & mask_q);
			wake <= sleep & flag_q[`TMR_ST_OVF] & mask_q[`TMR_ST_OVF];
		end
	end
endmodule

// *** src/tmr_consts.vh ***
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// register byte addresses
`define TMR_ADDR_CTRL 12'h000
`define TMR_ADDR_CNT_LO 12'h004
`define TMR_ADDR_CNT_HI 12'h008
`define TMR_ADDR_STATUS 12'h00C
`define TMR_ADDR_MASK 12'h010
// control field positions
`define TMR_CTRL_RUN 0
`define TMR_CTRL_WIDE 1
`define TMR_CTRL_NOSYNC 2
`define TMR_CTRL_EXTSEL 3
`define TMR_CTRL_PS_LO 4
`define TMR_CTRL_PS_HI 5
`define TMR_CTRL_GPOL 6
`define TMR_CTRL_W 7
// status bits
`define TMR_ST_OVF 0
`define TMR_ST_GATE 1
// reset values
`define TMR_CTRL_RST 7'h00
`define TMR_CNT_RST 16'h0000
`endif

// *** test/tmr_timer_asserts.sv ***
`timescale 1ns/1ps
module tmr_chk (
	input wire pclk, input wire presetn, input wire psel,
	input wire penable, input wire pwrite, input wire [11:0] paddr,
	input wire [31:0] prdata, input wire pready, input wire pslverr,
	input wire sleep, input wire irq, input wire wake);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && !pready;
	wire hole = paddr > 12'h010;
	AST_ANS: assert property (acc |=> pready) else $error("no ready");
	AST_PULSE: assert property (pready |=> !pready) else $error("ready long");
	AST_CAUSE: assert property (pready |-> $past(acc)) else $error("stray");
	AST_ERR: assert property (acc && hole |=> pslverr) else $error("no err");
	AST_OKAY: assert property (pready && !hole |-> !pslverr)
		else $error("bad err");
	AST_ZERO: assert property (acc && hole && !pwrite |=> prdata == 0)
		else $error("hole data");
	AST_HOLD: assert property (!pready |-> $stable(prdata)) else $error("moved");
	AST_WAKE: assert property (wake |-> irq && $past(sleep))
		else $error("bad wake");
endmodule
bind tmr_timer tmr_chk u_chk (.*);

// *** test/tmr_timer_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_fail++; $display("Error %s exp %h got %h", n, e, g); end end
module tmr_timer_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic ext_clk = 0, gate_in = 0, sleep = 0, pready, pslverr, irq, wake;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, ex, q[$];
	logic [15:0] r = 16'h539e;
	int n_fail = 0, check_count = 0, cyc = 0;
	tmr_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk(ext_clk), .gate_in(gate_in),
		.sleep(sleep), .irq(irq), .wake(wake));
	initial forever #2 pclk = ~pclk;
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task conclude;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (!pready);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		wr(a, 0, 0);
	endtask
	always @(posedge pclk) begin
		cyc++;
		ext_clk <= ~ext_clk;
		if (cyc == 3000) begin
			n_fail++;
			conclude;
		end
		if (psel && penable && pready) begin
			`CHK("slverr", paddr > 12'h010, pslverr)
			if (!pwrite) begin
				ex = q.pop_front();
				`CHK("prdata", ex, prdata)
			end
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(12'h000, 0);
		rd(12'h014, 0);
		wr(12'h000, 2);
		r = lfsr(r);
		wr(12'h008, r[15:8]);
		wr(12'h004, r[7:0]);
		rd(12'h004, r[7:0]);
		rd(12'h008, r[15:8]);
		for (int p = 0; p < 4; p++) begin
			wr(12'h008, 0);
			wr(12'h004, 0);
			// 64 run edges: a one-edge shift of the window changes the count at divide by 1
			wr(12'h000, 3 | p << 4);
			repeat (60) @(posedge pclk);
			wr(12'h000, 2 | p << 4);
			rd(12'h004, 64 >> p);
			rd(12'h008, 0);
		end
		wr(12'h010, 1);
		wr(12'h008, 8'hff);
		wr(12'h004, 8'hf0);
		wr(12'h000, 3);
		gate_in <= 1;
		repeat (30) @(posedge pclk);
		sleep <= 1;
		repeat (3) @(posedge pclk);
		`CHK("irq", 1'b1, irq)
		`CHK("wake", 1'b1, wake)
		sleep <= 0;
		rd(12'h00c, 3);
		rd(12'h00c, 3);
		wr(12'h00c, 3);
		rd(12'h00c, 0);
		`CHK("irq", 1'b0, irq)
		wr(12'h000, 2);
		wr(12'h008, 8'hff);
		wr(12'h004, 8'hf0);
		wr(12'h000, 15);
		sleep <= 1;
		repeat (60) @(posedge pclk);
		`CHK("wake", 1'b1, wake)
		`CHK("irq", 1'b1, irq)
		wr(12'h000, 2);
		sleep <= 0;
		wr(12'h00c, 3);
		wr(12'h000, 0);
		wr(12'h008, 8'h5a);
		wr(12'h004, 8'h33);
		rd(12'h004, 8'h33);
		rd(12'h008, 8'h5a);
		conclude;
	end
endmodule
